// ---- dv/tcd_host_model.sv ----
`timescale 1ns/100ps
module tcd_host_model (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Waits for pready with no cycle limit; the bench watchdog cuts hangs
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so a stale value never passes for data
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    // Start-up order: software reset, load all, then a legal pointer
    task automatic init_seq();
        logic [31:0] q;
        logic err;
        xfer(1'b1, 8'h00, 32'hff, q, err);
        xfer(1'b1, 8'h00, 32'h5f, q, err);
        xfer(1'b1, 8'h00, 32'h01, q, err);
    endtask
endmodule // tcd_host_model

// ---- dv/tcd_top_tb.sv ----
`timescale 1ns/100ps
module tcd_top_tb;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic pready, pslverr, re, freq_out, wide_bus, seq_hold;
    logic wr_prefetch_off;
    logic [4:0] armed_out, toggle_out;
    int failures = 0;
    int check_count = 0;

    tcd_top tcd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .freq_out,
        .wide_bus, .seq_hold, .wr_prefetch_off, .armed_out, .toggle_out);

    tcd_host_model tcd_host_model_inst (.pclk, .prdata, .pready,
        .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic test_done();
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tcd_host_model_inst.xfer(1'b1, a, d, rv, re);
    endtask

    task automatic rd(input logic [7:0] a);
        tcd_host_model_inst.xfer(1'b0, a, 32'h0, rv, re);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask

    // Status outputs trail the executing edge by one register stage
    task automatic cmd(input logic [7:0] op);
        wr(8'h00, {24'h0, op});
        repeat (2) @(posedge pclk);
    endtask

    function automatic logic [7:0] ca(input int n, input int s);
        return 8'(32 + 16 * (n - 1) + 4 * s);
    endfunction

    task automatic t_reset();
        rd(8'h1c);
        chk(32'(re), 32'h1);
        rchk(ca(1, 3), 32'h800);
        rchk(8'h04, 32'h0);
        chk(32'(armed_out), 32'h0);
    endtask

    task automatic t_load_arm();
        wr(ca(1, 1), 32'h5);
        cmd(8'h61);
        rchk(ca(1, 0), 32'h5);
        chk(32'(armed_out), 32'h1);
        cmd(8'h24);
        chk(32'(armed_out), 32'h5);
        rchk(ca(1, 1), 32'h5);
    endtask

    task automatic t_step_save();
        cmd(8'hf1);
        rchk(ca(1, 0), 32'h4);
        cmd(8'ha1);
        rchk(ca(1, 2), 32'h4);
        chk(32'(armed_out), 32'h5);
        wr(ca(1, 2), 32'h77);
        cmd(8'h81);
        chk(32'(armed_out), 32'h4);
        rchk(ca(1, 2), 32'h4);
        cmd(8'hc4);
        chk(32'(armed_out), 32'h0);
        cmd(8'hf1);
        rchk(ca(1, 0), 32'h3);
        wr(ca(1, 1), 32'h9);
        cmd(8'h41);
        rchk(ca(1, 0), 32'h9);
        wr(ca(1, 3), 32'h808);
        cmd(8'hf1);
        rchk(ca(1, 0), 32'ha);
        cmd(8'ha1);
        rchk(ca(1, 2), 32'ha);
        cmd(8'h21);
        chk(32'(armed_out), 32'h1);
    endtask

    // Counter 4 reaches terminal count by a step from 1 to 0
    task automatic t_tc();
        wr(ca(4, 1), 32'h1);
        cmd(8'h68);
        cmd(8'hf4);
        cmd(8'hc8);
        chk(32'(armed_out[3]), 32'h1);
        cmd(8'hf4);
        chk(32'(armed_out[3]), 32'h0);
        cmd(8'h68);
        cmd(8'hf4);
        cmd(8'hc8);
        cmd(8'h68);
        chk(32'(armed_out[3]), 32'h1);
        rd(8'h0c);
        chk(32'(rv[27]), 32'h0);
        cmd(8'hf4);
        chk(32'(armed_out[3]), 32'h1);
    endtask

    task automatic t_toggle();
        wr(ca(2, 3), 32'h802);
        cmd(8'hea);
        chk(32'(toggle_out), 32'h2);
        cmd(8'heb);
        chk(32'(toggle_out), 32'h2);
        cmd(8'he2);
        chk(32'(toggle_out), 32'h0);
    endtask

    task automatic t_mm();
        logic [7:0] ops [6] = '{8'he8, 8'hef, 8'hee, 8'he0, 8'he7, 8'he6};
        logic [15:0] mms [6] = '{16'h4300, 16'h6300, 16'h7300,
            16'h3300, 16'h1300, 16'h0300};
        int n;
        wr(8'h04, 32'h300);
        for (int i = 0; i < 6; i++) begin
            cmd(ops[i]);
            rchk(8'h04, 32'(mms[i]));
            chk(32'({seq_hold, wide_bus}), 32'(mms[i][14:13]));
        end
        cmd(8'hee);
        n = 0;
        repeat (16) begin
            @(posedge pclk);
            n += int'(freq_out);
        end
        chk(32'(n), 32'h0);
        cmd(8'he6);
        n = 0;
        repeat (16) begin
            @(posedge pclk);
            n += int'(freq_out);
        end
        chk(32'(n != 0), 32'h1);
    endtask

    task automatic t_ptr();
        cmd(8'h0b);
        rchk(8'h08, 32'h2b);
        rd(8'h10);
        rchk(8'h08, 32'h0b);
        cmd(8'he8);
        rd(8'h10);
        rchk(8'h08, 32'h0b);
        cmd(8'he0);
        cmd(8'h16);
        rchk(8'h08, 32'h0b);
        cmd(8'h08);
        rchk(8'h08, 32'h0b);
    endtask

    task automatic t_pf_mreset();
        cmd(8'hf9);
        chk(32'(wr_prefetch_off), 32'h1);
        cmd(8'he0);
        chk(32'(wr_prefetch_off), 32'h1);
        cmd(8'hf8);
        chk(32'(wr_prefetch_off), 32'h0);
        cmd(8'hf9);
        wr(8'h04, 32'h1234);
        wr(ca(2, 1), 32'h55);
        wr(ca(2, 2), 32'h66);
        cmd(8'h3f);
        cmd(8'hff);
        chk(32'(armed_out), 32'h0);
        rchk(8'h04, 32'h0);
        rchk(ca(2, 1), 32'h0);
        rchk(ca(2, 2), 32'h0);
        rchk(ca(2, 3), 32'h800);
        chk(32'(wr_prefetch_off), 32'h0);
        rchk(8'h08, 32'h0b);
    endtask

    // Counters only move by command here, so load-and-arm is safe
    initial begin
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        tcd_host_model_inst.init_seq();
        t_reset();
        t_load_arm();
        t_step_save();
        t_tc();
        t_toggle();
        t_mm();
        t_ptr();
        t_pf_mreset();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        test_done();
    end
endmodule // tcd_top_tb

// ---- hw/tcd_top.sv ----
`timescale 1ns/100ps
`include "tcd_cfg.svh"

// Operation
// - Load-and-arm loads each selected counter, then arms it.
// - Load-and-arm reaching terminal count still re-arms for another cycle.
// - Arm phase makes next load before terminal count take hold register.
// - Disarm stops selected counters; counter at terminal count counts once first.
// - Leaving count may be load or step; load-and-arm cancels pending disarm.
// - Disarmed counters still load, save, and resume on arm.
// - Save copies present count into hold register without disturbing counting.
// - Disarm-and-save acts as disarm followed by save.
// - Set-toggle sets counter N flip-flop; output only in toggle mode 010.
// - Clear-toggle clears toggle flip-flop of counter 001 to 101.
// - Step moves counter by one, direction bit chooses, even disarmed.
// - Load-pointer copies element and group bits, sets byte-select bit.
// - Pointer updates only for group 001, 010, 011, 100, 101, 111.
// - Sequencing commands set/clear mode bit 14; set bit freezes pointer.
// - Wide-bus command sets bit 13; data uses all 16 lines.
// - Narrow-bus command clears bit 13; data moves a byte at a time.
// - Gate-off sets bit 12, output low; clear drives divided frequency.
// - Write prefetch stays off until enable command or reset.
// - Opcode FF disarms all, zeroes mode/load/hold, modes get 0800.
// - No reset initialises the data pointer.
// - Arm only arms selected counters, never disarms others.
// - Load takes load or hold per mode; sources stay unchanged.
// - Top bits 110 disarm the selected counters.
// - Top bits 101 save the selected counters.
module tcd_top
    import tcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic freq_out,
    output logic wide_bus,
    output logic seq_hold,
    output logic wr_prefetch_off,
    output logic [4:0] armed_out,
    output logic [4:0] toggle_out
);
    logic [15:0] cnt [5];
    logic [15:0] ldr [5];
    logic [15:0] hld [5];
    logic [15:0] cmr [5];
    logic [15:0] mm;
    logic [5:0] dptr;
    logic [4:0] alt_hold;
    logic [3:0] div_cnt;
    logic fsig;
    tcd_cnt_status_t st;
    tcd_cmd_t c;
    logic acc;
    logic wr;
    logic cmd_go;
    logic [31:0] rd_data;
    logic rd_hit;

    function automatic tcd_cmd_t decode(input logic [7:0] op);
        tcd_cmd_t d;
        logic [4:0] nsel;
        d = '0;
        nsel = 5'h00;
        if (op[2:0] >= 3'h1 && op[2:0] <= 3'h5) begin
            nsel = 5'h01 << (op[2:0] - 3'h1);
        end
        case (op[7:5])
            3'h0: d.ldptr = op[2:0] != `TCD_GRP_BAD0 &&
                            op[2:0] != `TCD_GRP_BAD1;
            3'h1: d.arm = 1'b1;
            3'h2: d.load = 1'b1;
            3'h3: begin
                d.load = 1'b1;
                d.arm = 1'b1;
            end
            3'h4: begin
                d.disarm = 1'b1;
                d.save = 1'b1;
            end
            3'h5: d.save = 1'b1;
            3'h6: d.disarm = 1'b1;
            default: begin
                d.seq_off = op[4:0] == `TCD_OP_SEQ_OFF;
                d.seq_on = op[4:0] == `TCD_OP_SEQ_ON;
                d.wide = op[4:0] == `TCD_OP_WIDE;
                d.narrow = op[4:0] == `TCD_OP_NARROW;
                d.gate_off = op[4:0] == `TCD_OP_GATE_OFF;
                d.gate_on = op[4:0] == `TCD_OP_GATE_ON;
                d.pf_on = op[4:0] == `TCD_OP_PF_ON;
                d.pf_off = op[4:0] == `TCD_OP_PF_OFF;
                d.mreset = op[4:0] == `TCD_OP_MRESET;
                d.tog_set = op[4:3] == 2'h1 && nsel != 5'h00;
                d.tog_clr = op[4:3] == 2'h0 && nsel != 5'h00;
                d.step = op[4:3] == 2'h2 && nsel != 5'h00;
                nsel = (d.tog_set || d.tog_clr || d.step) ? nsel : 5'h00;
            end
        endcase
        d.sel = (op[7:5] == 3'h7) ? nsel : op[4:0];
        return d;
    endfunction

    function automatic logic [15:0] stepped(input int i);
        return cmr[i][`TCD_CM_DIR] ? cnt[i] + 16'h0001
                                   : cnt[i] - 16'h0001;
    endfunction

    // Zero wait states: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    // Decoded only on the completing edge, so each write runs once
    assign cmd_go = wr && paddr == `TCD_OFF_CMD;
    assign c = cmd_go ? decode(pwdata[7:0]) : '0;

    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h0000_0000;
        if (paddr[1:0] != 2'h0) begin
            rd_hit = 1'b0;
        end else if (paddr == `TCD_OFF_CMD) begin
            rd_data = 32'h0000_0000;
        end else if (paddr == `TCD_OFF_MM) begin
            rd_data = {16'h0000, mm};
        end else if (paddr == `TCD_OFF_DPTR) begin
            rd_data = {26'h0000000, dptr};
        end else if (paddr == `TCD_OFF_STAT) begin
            rd_data = {1'b0, dptr[5], wr_prefetch_off, st.pend, 3'h0,
                       st.toggle, 3'h0, st.tc, 3'h0, st.armed};
        end else if (paddr == `TCD_OFF_DATA) begin
            rd_data = 32'h0000_0000;
        end else if (paddr[6:4] >= `TCD_CNT_FIRST &&
                     paddr[6:4] <= `TCD_CNT_LAST && !paddr[7]) begin
            if (paddr[3:2] == `TCD_CNT_SUB_COUNT) begin
                rd_data = {16'h0000, cnt[paddr[6:4] - `TCD_CNT_FIRST]};
            end else if (paddr[3:2] == `TCD_CNT_SUB_LOAD) begin
                rd_data = {16'h0000, ldr[paddr[6:4] - `TCD_CNT_FIRST]};
            end else if (paddr[3:2] == `TCD_CNT_SUB_HOLD) begin
                rd_data = {16'h0000, hld[paddr[6:4] - `TCD_CNT_FIRST]};
            end else begin
                rd_data = {16'h0000, cmr[paddr[6:4] - `TCD_CNT_FIRST]};
            end
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= rd_hit ? rd_data : 32'h0000_0000;
            pslverr <= !rd_hit;
        end
    end

    // Counter, load, hold and mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                cnt[i] <= `TCD_REG_RST;
                ldr[i] <= `TCD_REG_RST;
                hld[i] <= `TCD_REG_RST;
                cmr[i] <= `TCD_CMR_RST;
            end
        end else if (c.mreset) begin
            for (int i = 0; i < 5; i++) begin
                ldr[i] <= `TCD_REG_RST;
                hld[i] <= `TCD_REG_RST;
                cmr[i] <= `TCD_CMR_RST;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (c.load && c.sel[i]) begin
                    // Source registers are only read here
                    cnt[i] <= (cmr[i][`TCD_CM_HOLD_SRC] ||
                               (cmr[i][`TCD_CM_ALT] && alt_hold[i]))
                              ? hld[i] : ldr[i];
                end else if (c.step && c.sel[i]) begin
                    cnt[i] <= stepped(i);
                end
                if (c.save && c.sel[i]) begin
                    hld[i] <= cnt[i];
                end
                if (wr && paddr[6:4] == 3'(i) + `TCD_CNT_FIRST &&
                    !paddr[7] && paddr[1:0] == 2'h0) begin
                    if (paddr[3:2] == `TCD_CNT_SUB_COUNT) begin
                        cnt[i] <= pwdata[15:0];
                    end else if (paddr[3:2] == `TCD_CNT_SUB_LOAD) begin
                        ldr[i] <= pwdata[15:0];
                    end else if (paddr[3:2] == `TCD_CNT_SUB_HOLD) begin
                        hld[i] <= pwdata[15:0];
                    end else begin
                        cmr[i] <= pwdata[15:0];
                    end
                end
            end
        end
    end

    // Arming, terminal count, deferred disarm and reload alternation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.armed <= 5'h00;
            st.tc <= 5'h00;
            st.pend <= 5'h00;
            st.toggle <= 5'h00;
            alt_hold <= 5'h1f;
        end else if (c.mreset) begin
            st.armed <= 5'h00;
            st.pend <= 5'h00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                // Toggle lives here so the status struct has one writer
                if (c.tog_set && c.sel[i]) begin
                    st.toggle[i] <= 1'b1;
                end else if (c.tog_clr && c.sel[i]) begin
                    st.toggle[i] <= 1'b0;
                end
                if (c.load && c.sel[i]) begin
                    st.tc[i] <= 1'b0;
                end else if (c.step && c.sel[i]) begin
                    st.tc[i] <= stepped(i) == 16'h0000;
                    if (stepped(i) == 16'h0000 && cmr[i][`TCD_CM_ALT]) begin
                        alt_hold[i] <= !alt_hold[i];
                    end
                end
                if (c.arm && c.sel[i]) begin
                    // Arm phase follows the load, so it wins here
                    st.armed[i] <= 1'b1;
                    st.pend[i] <= 1'b0;
                    alt_hold[i] <= 1'b1;
                end else if (c.disarm && c.sel[i]) begin
                    if (st.tc[i]) begin
                        st.pend[i] <= 1'b1;
                    end else begin
                        st.armed[i] <= 1'b0;
                    end
                end else if (st.pend[i] && (c.load || c.step) &&
                             c.sel[i]) begin
                    st.armed[i] <= 1'b0;
                    st.pend[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mm <= `TCD_MM_RST;
        end else if (c.mreset) begin
            mm <= `TCD_MM_RST;
        end else if (wr && paddr == `TCD_OFF_MM) begin
            mm <= pwdata[15:0];
        end else if (c.seq_off || c.seq_on) begin
            mm[`TCD_MM_SEQ] <= c.seq_off;
        end else if (c.wide || c.narrow) begin
            mm[`TCD_MM_WIDE] <= c.wide;
        end else if (c.gate_off || c.gate_on) begin
            mm[`TCD_MM_GATE] <= c.gate_off;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_prefetch_off <= 1'b0;
        end else if (c.pf_off) begin
            wr_prefetch_off <= 1'b1;
        end else if (c.pf_on || c.mreset) begin
            wr_prefetch_off <= 1'b0;
        end
    end

    // Left without reset on purpose: software must load it after reset
    always_ff @(posedge pclk) begin
        if (c.ldptr) begin
            dptr <= {1'b1, pwdata[4:0]};
        end else if (acc && paddr == `TCD_OFF_DATA &&
                     !mm[`TCD_MM_SEQ]) begin
            if (mm[`TCD_MM_WIDE] || !dptr[5]) begin
                dptr[4:3] <= dptr[4:3] + 2'h1;
                dptr[5] <= 1'b1;
            end else begin
                dptr[5] <= 1'b0;
            end
        end
    end

    // Divide rate is taken from mode bits 11:8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'h0;
            fsig <= 1'b0;
        end else if (div_cnt >= mm[11:8]) begin
            div_cnt <= 4'h0;
            fsig <= !fsig;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_out <= 1'b0;
            wide_bus <= 1'b0;
            seq_hold <= 1'b0;
            armed_out <= 5'h00;
            toggle_out <= 5'h00;
        end else begin
            freq_out <= fsig && !mm[`TCD_MM_GATE];
            wide_bus <= mm[`TCD_MM_WIDE];
            seq_hold <= mm[`TCD_MM_SEQ];
            armed_out <= st.armed;
            for (int i = 0; i < 5; i++) begin
                toggle_out[i] <= st.toggle[i] &&
                    cmr[i][2:0] == `TCD_OC_TOGGLE;
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ldarm;
        c.load && c.arm |=> (st.armed & $past(c.sel)) == $past(c.sel);
    endproperty
    a_ldarm: assert property (p_ldarm) else $error("ldarm not armed");

    property p_arm_keep;
        c.arm |=> (st.armed & ~$past(c.sel)) ==
                  ($past(st.armed) & ~$past(c.sel));
    endproperty
    a_arm_keep: assert property (p_arm_keep) else $error("arm disarmed");

    property p_dis_tc;
        c.disarm && !c.arm && (c.sel & st.tc) != 5'h00 |=>
            (st.pend & $past(c.sel & st.tc)) == $past(c.sel & st.tc);
    endproperty
    a_dis_tc: assert property (p_dis_tc) else $error("no pend");

    property p_dis;
        c.disarm |=> (st.armed & $past(c.sel & ~st.tc)) == 5'h00;
    endproperty
    a_dis: assert property (p_dis) else $error("still armed");

    property p_cancel;
        c.load && c.arm && (st.pend & c.sel) != 5'h00 |=>
            (st.pend & $past(c.sel)) == 5'h00;
    endproperty
    a_cancel: assert property (p_cancel) else $error("pend kept");

    property p_save;
        c.save && c.sel[0] |=> hld[0] == $past(cnt[0]);
    endproperty
    a_save: assert property (p_save) else $error("save lost");

    property p_seq;
        c.seq_off |=> mm[`TCD_MM_SEQ] && mm[13:0] == $past(mm[13:0])
                      ##1 seq_hold;
    endproperty
    a_seq: assert property (p_seq) else $error("seq bit");

    property p_gate;
        mm[`TCD_MM_GATE] |=> !freq_out;
    endproperty
    a_gate: assert property (p_gate) else $error("divided_freq_output on");

    property p_pf;
        c.pf_off |=> wr_prefetch_off;
    endproperty
    a_pf: assert property (p_pf) else $error("prefetch");

    property p_pf_keep;
        wr_prefetch_off && !c.pf_on && !c.mreset |=> wr_prefetch_off;
    endproperty
    a_pf_keep: assert property (p_pf_keep) else $error("pf lost");

    property p_mrst;
        c.mreset |=> mm == `TCD_MM_RST && st.armed == 5'h00 &&
                     cmr[4] == `TCD_CMR_RST ##1 armed_out == 5'h00;
    endproperty
    a_mrst: assert property (p_mrst) else $error("mreset");

    property p_ptr;
        cmd_go && pwdata[7:5] == 3'h0 && !c.ldptr |=> $stable(dptr);
    endproperty
    a_ptr: assert property (p_ptr) else $error("dptr moved");

    c_ldarm: cover property (c.load && c.arm && c.sel == 5'h1f);
    c_pend: cover property (st.pend != 5'h00 ##[1:20] st.pend == 5'h00);
    c_step: cover property (c.step ##1 st.tc != 5'h00);
    c_mrst: cover property (c.mreset);
endmodule // tcd_top

// ---- inc/tcd_cfg.svh ----
`ifndef TCD_CFG_SVH
`define TCD_CFG_SVH
`define TCD_OFF_CMD 8'h00
`define TCD_OFF_MM 8'h04
`define TCD_OFF_DPTR 8'h08
`define TCD_OFF_STAT 8'h0c
`define TCD_OFF_DATA 8'h10
`define TCD_CNT_FIRST 3'h2
`define TCD_CNT_LAST 3'h6
`define TCD_CNT_SUB_COUNT 2'h0
`define TCD_CNT_SUB_LOAD 2'h1
`define TCD_CNT_SUB_HOLD 2'h2
`define TCD_CNT_SUB_MODE 2'h3
`define TCD_MM_RST 16'h0000
`define TCD_REG_RST 16'h0000
`define TCD_CMR_RST 16'h0800
`define TCD_MM_GATE 12
`define TCD_MM_WIDE 13
`define TCD_MM_SEQ 14
`define TCD_CM_DIR 3
`define TCD_CM_HOLD_SRC 12
`define TCD_CM_ALT 13
`define TCD_OC_TOGGLE 3'h2
`define TCD_ST_TC 8
`define TCD_ST_TOG 16
`define TCD_ST_PEND 24
`define TCD_ST_PF 29
`define TCD_ST_BSEL 30
`define TCD_GRP_BAD0 3'h0
`define TCD_GRP_BAD1 3'h6
`define TCD_OP_SEQ_OFF 5'h08
`define TCD_OP_SEQ_ON 5'h00
`define TCD_OP_WIDE 5'h0f
`define TCD_OP_NARROW 5'h07
`define TCD_OP_GATE_OFF 5'h0e
`define TCD_OP_GATE_ON 5'h06
`define TCD_OP_PF_ON 5'h18
`define TCD_OP_PF_OFF 5'h19
`define TCD_OP_MRESET 5'h1f
`endif

// ---- inc/tcd_pkg.sv ----
package tcd_pkg;
    typedef struct packed {
        logic arm;
        logic load;
        logic disarm;
        logic save;
        logic tog_set;
        logic tog_clr;
        logic step;
        logic ldptr;
        logic seq_off;
        logic seq_on;
        logic wide;
        logic narrow;
        logic gate_off;
        logic gate_on;
        logic pf_on;
        logic pf_off;
        logic mreset;
        logic [4:0] sel;
    } tcd_cmd_t;

    typedef struct packed {
        logic [4:0] armed;
        logic [4:0] tc;
        logic [4:0] pend;
        logic [4:0] toggle;
    } tcd_cnt_status_t;
endpackage
